// File: logic/ifd_pkg.sv
// Purpose: shared types and constants for the instruction field decoder
// Assumes: 32-bit apb data, 18-bit storage addresses
// Notes: instruction bit 0 is the msb of the word
`default_nettype none
package ifd_pkg;
  localparam int ADDR_W = 18;
  // instruction word fields, leftmost bit first
  typedef struct packed {
    logic ind;
    logic [1:0] xsel;
    logic lit;
    logic [6:0] op;
    logic [1:0] mods;
    logic cs;
    logic [17:0] addr;
  } ifd_instr_t;
  // single precision floating point layout
  typedef struct packed {
    logic sign;
    logic [6:0] expo;
    logic [23:0] frac;
  } ifd_fp_t;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } ifd_apb_req_t;
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } ifd_apb_rsp_t;
  typedef struct packed {
    logic req;
    logic wr;
    logic [17:0] addr;
    logic [31:0] wdata;
  } ifd_mem_req_t;
  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
  } ifd_mem_rsp_t;
  typedef enum logic [1:0] {SZ_BYTE, SZ_HALF, SZ_WORD, SZ_DWORD} ifd_size_t;
  // operation classes
  localparam logic [1:0] CL_ACC = 2'h0;
  localparam logic [1:0] CL_INDEX = 2'h1;
  localparam logic [1:0] CL_BRANCH = 2'h2;
  // condition code values
  localparam logic [1:0] CC_ZERO = 2'h0;
  localparam logic [1:0] CC_POS = 2'h1;
  localparam logic [1:0] CC_NEG = 2'h2;
  // condition code modes
  localparam logic [1:0] CCM_SIGN = 2'h0;
  localparam logic [1:0] CCM_LOGIC = 2'h1;
  localparam logic [1:0] CCM_CMP = 2'h2;
  // register offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_INSTR = 8'h08;
  localparam logic [7:0] OFF_IDX1 = 8'h0c;
  localparam logic [7:0] OFF_IDX2 = 8'h10;
  localparam logic [7:0] OFF_IDX3 = 8'h14;
  localparam logic [7:0] OFF_ACCA = 8'h18;
  localparam logic [7:0] OFF_ACCB = 8'h1c;
  localparam logic [7:0] OFF_EA = 8'h20;
  localparam logic [7:0] OFF_OPHI = 8'h24;
  localparam logic [7:0] OFF_OPLO = 8'h28;
  localparam logic [7:0] OFF_FP = 8'h2c;
  localparam logic [7:0] OFF_FPFRAC = 8'h30;
  localparam logic [7:0] OFF_STDATA = 8'h34;
  // control and status bit positions
  localparam int CTRL_START = 0;
  localparam int CTRL_STORE = 1;
  localparam int CTRL_CCM = 4;
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_INVOP = 2;
  localparam int ST_INVADDR = 3;
  localparam int ST_MISAL = 4;
  localparam int ST_TAKEN = 5;
  localparam int ST_CC = 8;
  localparam logic [17:0] DW_STEP = 18'h00004;
endpackage : ifd_pkg
`default_nettype wire

// File: logic/ifd_decoder.sv
// Purpose: instruction field decode and effective address resolution
// Assumes: word storage port, one clock, apb register access
// Notes: an endless indirect chain keeps the block busy until reset
`timescale 1ns/1ps
`default_nettype none
module ifd_decoder #(
  parameter logic [17:0] MEM_TOP = 18'h3ffff,
  parameter logic [15:0] OP_VALID = 16'h7fff
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register bus
  input wire ifd_pkg::ifd_apb_req_t apb_i,
  output ifd_pkg::ifd_apb_rsp_t apb_o,
  // core storage
  output ifd_pkg::ifd_mem_req_t mem_o,
  input wire ifd_pkg::ifd_mem_rsp_t mem_i,
  // status
  output logic busy,
  output logic pgm_int
);
  if (MEM_TOP[1:0] != 2'h3)
  begin : g_chk
    $error("storage top must end a word");
  end

  typedef enum logic [2:0] {
    S_IDLE, S_RESOLVE, S_IND, S_OPD, S_OPD2, S_WR, S_DONE
  } ifd_fsm_t;

  typedef struct packed {
    ifd_fsm_t fsm;
    logic [31:0] instr;
    logic [31:0] cur;
    logic [31:0] a;
    logic [31:0] b;
    logic [31:0] op_hi;
    logic [31:0] op_lo;
    logic [31:0] stdata;
    logic [31:0] prdata;
    logic [2:0][17:0] idx;
    logic [17:0] ea;
    logic [17:0] maddr;
    logic [31:0] mwdata;
    logic store;
    logic [1:0] ccm;
    logic done;
    logic inv_op;
    logic inv_addr;
    logic misal;
    logic taken;
    logic [1:0] cc;
    logic pslverr;
    logic pgm_int;
  } ifd_state_t;

  ifd_state_t state_q;
  ifd_state_t state_d;

  function automatic logic [17:0] idx_of(
    input logic [1:0] x,
    input logic [2:0][17:0] r
  );
    logic [1:0] k;
    k = x - 2'h1;
    return (x == 2'h0) ? 18'h00000 : r[k];
  endfunction : idx_of

  function automatic logic [4:0] byte_sh(input logic [1:0] p);
    return {~p, 3'b000};
  endfunction : byte_sh

  function automatic ifd_pkg::ifd_size_t op_size(input logic [6:0] op);
    return ifd_pkg::ifd_size_t'(op[1:0]);
  endfunction : op_size

  function automatic logic aligned(
    input ifd_pkg::ifd_size_t sz,
    input logic [17:0] ea
  );
    logic ok;
    unique case (sz)
      ifd_pkg::SZ_BYTE: ok = 1'b1;
      ifd_pkg::SZ_HALF: ok = ~ea[0];
      ifd_pkg::SZ_WORD, ifd_pkg::SZ_DWORD: ok = (ea[1:0] == 2'h0);
    endcase
    return ok;
  endfunction : aligned

  function automatic logic [1:0] cc_of(
    input logic [1:0] m,
    input logic [31:0] v,
    input logic [31:0] a
  );
    logic [1:0] c;
    if (m == ifd_pkg::CCM_LOGIC)
      c = (&v) ? ifd_pkg::CC_POS : (v == 32'h0) ? ifd_pkg::CC_ZERO
        : ifd_pkg::CC_NEG;
    else if (m == ifd_pkg::CCM_CMP)
      c = ($signed(a) > $signed(v)) ? ifd_pkg::CC_POS
        : (a == v) ? ifd_pkg::CC_ZERO : ifd_pkg::CC_NEG;
    else
      c = (v == 32'h0) ? ifd_pkg::CC_ZERO
        : v[31] ? ifd_pkg::CC_NEG : ifd_pkg::CC_POS;
    return c;
  endfunction : cc_of

  function automatic logic cond_met(
    input logic [1:0] m,
    input logic [1:0] cc
  );
    logic t;
    unique case (m)
      2'h0: t = 1'b1;
      2'h1: t = (cc == ifd_pkg::CC_ZERO);
      2'h2: t = (cc == ifd_pkg::CC_POS);
      2'h3: t = (cc == ifd_pkg::CC_NEG);
    endcase
    return t;
  endfunction : cond_met

  ifd_pkg::ifd_instr_t ins;
  ifd_pkg::ifd_instr_t cw;
  ifd_pkg::ifd_fp_t fp;
  ifd_pkg::ifd_size_t sz;
  logic [17:0] ea_n;
  logic [17:0] ea4;
  logic [4:0] sh;
  logic [31:0] mask;
  logic [31:0] rdv;
  logic [31:0] v;
  logic hit;
  logic wr;

  assign ins = ifd_pkg::ifd_instr_t'(state_q.instr);
  assign cw = ifd_pkg::ifd_instr_t'(state_q.cur);
  assign fp = ifd_pkg::ifd_fp_t'(state_q.op_hi);
  assign sz = op_size(ins.op);
  // 18-bit sum wraps on purpose
  assign ea_n = cw.addr + idx_of(cw.xsel, state_q.idx);
  assign ea4 = state_q.ea + ifd_pkg::DW_STEP;

  always_comb
  begin
    hit = 1'b1;
    rdv = 32'h00000000;
    unique case (apb_i.paddr)
      ifd_pkg::OFF_CTRL:
      begin
        rdv[ifd_pkg::CTRL_STORE] = state_q.store;
        rdv[ifd_pkg::CTRL_CCM +: 2] = state_q.ccm;
      end
      ifd_pkg::OFF_STAT:
      begin
        rdv[ifd_pkg::ST_BUSY] = (state_q.fsm != S_IDLE);
        rdv[ifd_pkg::ST_DONE] = state_q.done;
        rdv[ifd_pkg::ST_INVOP] = state_q.inv_op;
        rdv[ifd_pkg::ST_INVADDR] = state_q.inv_addr;
        rdv[ifd_pkg::ST_MISAL] = state_q.misal;
        rdv[ifd_pkg::ST_TAKEN] = state_q.taken;
        rdv[ifd_pkg::ST_CC +: 2] = state_q.cc;
      end
      ifd_pkg::OFF_INSTR: rdv = state_q.instr;
      ifd_pkg::OFF_IDX1: rdv = {14'h0, state_q.idx[0]};
      ifd_pkg::OFF_IDX2: rdv = {14'h0, state_q.idx[1]};
      ifd_pkg::OFF_IDX3: rdv = {14'h0, state_q.idx[2]};
      ifd_pkg::OFF_ACCA: rdv = state_q.a;
      ifd_pkg::OFF_ACCB: rdv = state_q.b;
      ifd_pkg::OFF_EA: rdv = {14'h0, state_q.ea};
      ifd_pkg::OFF_OPHI: rdv = state_q.op_hi;
      ifd_pkg::OFF_OPLO: rdv = state_q.op_lo;
      ifd_pkg::OFF_FP: rdv = {24'h0, fp.sign, fp.expo};
      ifd_pkg::OFF_FPFRAC: rdv = {8'h0, fp.frac};
      ifd_pkg::OFF_STDATA: rdv = state_q.stdata;
      default: hit = 1'b0;
    endcase
  end

  always_comb
  begin
    state_d = state_q;
    state_d.pgm_int = 1'b0;
    sh = byte_sh(state_q.ea[1:0]);
    mask = 32'h000000ff << sh;
    v = state_q.op_hi;
    wr = apb_i.psel & apb_i.penable & apb_i.pwrite & ~state_q.pslverr;
    // read data and error latched in setup, stable through access
    if (apb_i.psel & ~apb_i.penable)
    begin
      state_d.prdata = rdv;
      state_d.pslverr = ~hit;
    end
    if (wr)
    begin
      unique case (apb_i.paddr)
        ifd_pkg::OFF_CTRL:
        begin
          state_d.store = apb_i.pwdata[ifd_pkg::CTRL_STORE];
          state_d.ccm = apb_i.pwdata[ifd_pkg::CTRL_CCM +: 2];
        end
        ifd_pkg::OFF_STAT:
        begin
          // clear first so a same-cycle set below still lands
          if (apb_i.pwdata[ifd_pkg::ST_DONE])
            state_d.done = 1'b0;
          if (apb_i.pwdata[ifd_pkg::ST_INVOP])
            state_d.inv_op = 1'b0;
          if (apb_i.pwdata[ifd_pkg::ST_INVADDR])
            state_d.inv_addr = 1'b0;
          if (apb_i.pwdata[ifd_pkg::ST_MISAL])
            state_d.misal = 1'b0;
          if (apb_i.pwdata[ifd_pkg::ST_TAKEN])
            state_d.taken = 1'b0;
        end
        ifd_pkg::OFF_INSTR: state_d.instr = apb_i.pwdata;
        ifd_pkg::OFF_IDX1: state_d.idx[0] = apb_i.pwdata[17:0];
        ifd_pkg::OFF_IDX2: state_d.idx[1] = apb_i.pwdata[17:0];
        ifd_pkg::OFF_IDX3: state_d.idx[2] = apb_i.pwdata[17:0];
        ifd_pkg::OFF_ACCA: state_d.a = apb_i.pwdata;
        ifd_pkg::OFF_ACCB: state_d.b = apb_i.pwdata;
        ifd_pkg::OFF_STDATA: state_d.stdata = apb_i.pwdata;
        default: state_d.done = state_d.done;
      endcase
    end
    unique case (state_q.fsm)
      S_IDLE:
      begin
        if (wr && apb_i.paddr == ifd_pkg::OFF_CTRL
            && apb_i.pwdata[ifd_pkg::CTRL_START])
        begin
          state_d.done = 1'b0;
          state_d.taken = 1'b0;
          if (!OP_VALID[ins.op[6:3]])
          begin
            state_d.inv_op = 1'b1;
            state_d.pgm_int = 1'b1;
            state_d.done = 1'b1;
          end
          else
          begin
            state_d.cur = state_q.instr;
            state_d.fsm = S_RESOLVE;
          end
        end
      end
      S_RESOLVE:
      begin
        state_d.ea = ea_n;
        if (cw.ind)
        begin
          // every pointer word is itself a word operand
          if (ea_n > MEM_TOP)
          begin
            state_d.inv_addr = 1'b1;
            state_d.pgm_int = 1'b1;
            state_d.done = 1'b1;
            state_d.fsm = S_IDLE;
          end
          else if (ea_n[1:0] != 2'h0)
          begin
            state_d.misal = 1'b1;
            state_d.done = 1'b1;
            state_d.fsm = S_IDLE;
          end
          else
          begin
            state_d.maddr = ea_n;
            state_d.fsm = S_IND;
          end
        end
        else if (ins.lit && !state_q.store)
        begin
          state_d.op_hi = {14'h0, ea_n};
          state_d.op_lo = 32'h00000000;
          state_d.fsm = S_DONE;
        end
        else if (ea_n > MEM_TOP)
        begin
          state_d.inv_addr = 1'b1;
          state_d.pgm_int = 1'b1;
          state_d.done = 1'b1;
          state_d.fsm = S_IDLE;
        end
        else if (!aligned(sz, ea_n))
        begin
          state_d.misal = 1'b1;
          state_d.done = 1'b1;
          state_d.fsm = S_IDLE;
        end
        else
        begin
          state_d.maddr = {ea_n[17:2], 2'b00};
          state_d.fsm = S_OPD;
        end
      end
      S_IND:
      begin
        if (mem_i.ack)
        begin
          // next level keeps its own indirect and index fields
          state_d.cur = mem_i.rdata;
          state_d.fsm = S_RESOLVE;
        end
      end
      S_OPD:
      begin
        if (mem_i.ack)
        begin
          if (state_q.store)
          begin
            unique case (sz)
              ifd_pkg::SZ_BYTE:
                state_d.mwdata = (mem_i.rdata & ~mask)
                  | ((state_q.stdata & 32'h000000ff) << sh);
              ifd_pkg::SZ_HALF:
                state_d.mwdata = state_q.ea[1]
                  ? {mem_i.rdata[31:16], state_q.stdata[15:0]}
                  : {state_q.stdata[15:0], mem_i.rdata[15:0]};
              ifd_pkg::SZ_WORD, ifd_pkg::SZ_DWORD:
                state_d.mwdata = state_q.stdata;
            endcase
            state_d.fsm = S_WR;
          end
          else if (sz == ifd_pkg::SZ_DWORD)
          begin
            state_d.op_hi = mem_i.rdata;
            if (ea4 > MEM_TOP)
            begin
              state_d.inv_addr = 1'b1;
              state_d.pgm_int = 1'b1;
              state_d.done = 1'b1;
              state_d.fsm = S_IDLE;
            end
            else
            begin
              state_d.maddr = ea4;
              state_d.fsm = S_OPD2;
            end
          end
          else
          begin
            unique case (sz)
              ifd_pkg::SZ_BYTE:
                state_d.op_hi = (mem_i.rdata >> sh) & 32'h000000ff;
              ifd_pkg::SZ_HALF:
                state_d.op_hi = {16'h0000, state_q.ea[1]
                  ? mem_i.rdata[15:0] : mem_i.rdata[31:16]};
              ifd_pkg::SZ_WORD, ifd_pkg::SZ_DWORD:
                state_d.op_hi = mem_i.rdata;
            endcase
            state_d.op_lo = 32'h00000000;
            state_d.fsm = S_DONE;
          end
        end
      end
      S_OPD2:
      begin
        if (mem_i.ack)
        begin
          state_d.op_lo = mem_i.rdata;
          state_d.fsm = S_DONE;
        end
      end
      S_WR:
      begin
        if (mem_i.ack)
          state_d.fsm = S_DONE;
      end
      S_DONE:
      begin
        if (state_q.store)
          v = state_q.stdata;
        else if (sz == ifd_pkg::SZ_DWORD && state_q.op_hi == 32'h0
                 && state_q.op_lo != 32'h0)
          v = 32'h00000001;
        if (!state_q.store)
        begin
          unique case (ins.op[3:2])
            ifd_pkg::CL_INDEX:
            begin
              if (ins.mods != 2'h0)
                state_d.idx[ins.mods - 2'h1] = state_q.op_hi[17:0];
              v = {14'h0, state_q.op_hi[17:0]};
            end
            ifd_pkg::CL_BRANCH:
              state_d.taken = cond_met(ins.mods, state_q.cc);
            default:
            begin
              // compare leaves the accumulators alone
              if (state_q.ccm != ifd_pkg::CCM_CMP)
              begin
                unique case (sz)
                  ifd_pkg::SZ_BYTE:
                    state_d.a[byte_sh(ins.mods) +: 8]
                      = state_q.op_hi[7:0];
                  ifd_pkg::SZ_HALF:
                    if (ins.mods[0])
                      state_d.a[15:0] = state_q.op_hi[15:0];
                    else
                      state_d.a[31:16] = state_q.op_hi[15:0];
                  ifd_pkg::SZ_WORD:
                    if (ins.mods == 2'h1)
                      state_d.b = state_q.op_hi;
                    else
                      state_d.a = state_q.op_hi;
                  ifd_pkg::SZ_DWORD:
                  begin
                    state_d.a = state_q.op_hi;
                    state_d.b = state_q.op_lo;
                  end
                endcase
              end
            end
          endcase
        end
        // compare relies on software setting the flag
        if (ins.cs && ins.op[3:2] != ifd_pkg::CL_BRANCH)
          state_d.cc = cc_of(state_q.ccm, v, state_q.a);
        state_d.done = 1'b1;
        state_d.fsm = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      state_q <= '0;
    else
      state_q <= state_d;
  end

  assign apb_o.pready = 1'b1;
  assign apb_o.pslverr = state_q.pslverr & apb_i.psel & apb_i.penable;
  assign apb_o.prdata = state_q.prdata;
  assign mem_o.req = (state_q.fsm == S_IND) || (state_q.fsm == S_OPD)
    || (state_q.fsm == S_OPD2) || (state_q.fsm == S_WR);
  assign mem_o.wr = (state_q.fsm == S_WR);
  assign mem_o.addr = state_q.maddr;
  assign mem_o.wdata = state_q.mwdata;
  assign busy = (state_q.fsm != S_IDLE);
  assign pgm_int = state_q.pgm_int;
endmodule : ifd_decoder
`default_nettype wire

// File: testbench/ifd_mem_model.sv
// Purpose: word storage partner for the decoder
// Assumes: 1024 words, answer after lat idle cycles
// Notes: read data is scrambled outside the ack cycle
`timescale 1ns/1ps
`default_nettype none
module ifd_mem_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // storage port
  input wire ifd_pkg::ifd_mem_req_t req_i,
  output ifd_pkg::ifd_mem_rsp_t rsp_o,
  // answer delay
  input wire logic [3:0] lat
);
  logic [31:0] word_q [0:1023];
  logic [3:0] cnt_q;
  logic [31:0] last_q;
  always @(posedge clk)
  begin
    rsp_o.ack <= 1'b0;
    // inverse of last word, so stale data never looks valid
    rsp_o.rdata <= ~last_q;
    if (rst)
      last_q <= 32'h0;
    if (rst || !req_i.req || rsp_o.ack)
      cnt_q <= 4'h0;
    else if (cnt_q < lat)
      cnt_q <= cnt_q + 4'h1;
    else
    begin
      rsp_o.ack <= 1'b1;
      rsp_o.rdata <= word_q[req_i.addr[11:2]];
      last_q <= word_q[req_i.addr[11:2]];
      if (req_i.wr)
        word_q[req_i.addr[11:2]] <= req_i.wdata;
    end
  end
endmodule : ifd_mem_model
`default_nettype wire

// File: testbench/ifd_monitor.sv
// Purpose: port checks for the decoder
// Assumes: one clock, synchronous reset
// Notes: sees only the top ports
`timescale 1ns/1ps
`default_nettype none
module ifd_monitor #(
  parameter logic [17:0] MEM_TOP = 18'h3ffff,
  parameter logic [15:0] OP_VALID = 16'h7fff
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // buses
  input wire ifd_pkg::ifd_apb_req_t apb_i,
  input wire ifd_pkg::ifd_apb_rsp_t apb_o,
  input wire ifd_pkg::ifd_mem_req_t mem_o,
  input wire ifd_pkg::ifd_mem_rsp_t mem_i,
  // status
  input wire logic busy,
  input wire logic pgm_int
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence start_wr;
    apb_i.psel && apb_i.penable && apb_i.pwrite && !busy &&
    apb_i.paddr == ifd_pkg::OFF_CTRL && apb_i.pwdata[ifd_pkg::CTRL_START];
  endsequence
  sequence kick;
    ##[1:2] (busy || pgm_int);
  endsequence
  sequence mem_wait;
    mem_o.req && !mem_i.ack;
  endsequence
  word_align_a: assert property (
    mem_o.req |-> mem_o.addr[1:0] == 2'h0)
    else $error("storage address not word aligned");
  req_hold_a: assert property (
    mem_wait |=> mem_o.req && $stable(mem_o.addr) && $stable(mem_o.wr)
    && $stable(mem_o.wdata))
    else $error("storage request changed before ack");
  addr_top_a: assert property (
    mem_o.req |-> mem_o.addr <= MEM_TOP)
    else $error("storage access past top");
  int_pulse_a: assert property (
    pgm_int |=> !pgm_int)
    else $error("program interrupt longer than one cycle");
  req_busy_a: assert property (mem_o.req |-> busy)
    else $error("storage request while idle");
  wr_req_a: assert property (mem_o.wr |-> mem_o.req)
    else $error("storage write strobe without request");
  start_kick_a: assert property (
    start_wr |-> kick)
    else $error("start did not begin a decode");
  err_phase_a: assert property (
    apb_o.pslverr |-> apb_i.psel && apb_i.penable)
    else $error("slave error outside access phase");
  ready_high_a: assert property (apb_o.pready)
    else $error("pready low");
  int_seen_c: cover property (pgm_int);
endmodule : ifd_monitor
bind ifd_decoder ifd_monitor #(.MEM_TOP(MEM_TOP), .OP_VALID(OP_VALID))
  u_mon (.clk(clk), .rst(rst), .apb_i(apb_i), .apb_o(apb_o),
  .mem_o(mem_o), .mem_i(mem_i), .busy(busy), .pgm_int(pgm_int));
`default_nettype wire

// File: testbench/test_instruction_field_decode_ea.sv
// Purpose: register level test of the decoder
// Assumes: storage top 0xfff, zero wait apb
// Notes: each decode is polled through the status word
`timescale 1ns/1ps
`default_nettype none
module test_instruction_field_decode_ea;
  logic clk = 1'b0;
  logic rst = 1'b1;
  ifd_pkg::ifd_apb_req_t apb_i = '0;
  ifd_pkg::ifd_apb_rsp_t apb_o;
  ifd_pkg::ifd_mem_req_t mem_o;
  ifd_pkg::ifd_mem_rsp_t mem_i;
  logic busy;
  logic pgm_int;
  logic [3:0] lat = 4'h0;
  logic [31:0] rd;
  logic err;
  logic [1:0] cc_exp [6] = '{2'h1, 2'h0, 2'h2, 2'h1, 2'h0, 2'h2};
  logic [6:0] mis_op [3] = '{7'h01, 7'h02, 7'h03};
  logic [17:0] mis_ad [3] = '{18'h00601, 18'h00602, 18'h00502};
  int n_fail = 0;
  int num_checks = 0;
  int n_int = 0;
  logic seen_busy = 1'b0;
  ifd_decoder #(.MEM_TOP(18'h00fff), .OP_VALID(16'h7fff)) dut (
    .clk(clk), .rst(rst), .apb_i(apb_i), .apb_o(apb_o),
    .mem_o(mem_o), .mem_i(mem_i), .busy(busy), .pgm_int(pgm_int));
  ifd_mem_model mem (.clk(clk), .rst(rst), .req_i(mem_o),
    .rsp_o(mem_i), .lat(lat));
  initial
  begin
    forever #50 clk = ~clk;
  end
  always @(posedge clk)
  begin
    if (pgm_int === 1'b1)
      n_int <= n_int + 1;
    if (busy === 1'b1)
      seen_busy <= 1'b1;
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk32
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int i;
    apb_i <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    apb_i.penable <= 1'b1;
    for (i = 0; i < 20; i++)
    begin
      @(posedge clk);
      if (apb_o.pready === 1'b1)
        break;
    end
    if (i == 20)
    begin
      n_fail++;
      report_and_stop();
    end
    rd = apb_o.prdata;
    err = apb_o.pslverr;
    apb_i <= '0;
    @(posedge clk);
  endtask : apb
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk32(rd, e);
  endtask : rdc
  // fields: {ind, xsel, lit}, opcode, modifier, cond set, address
  function automatic logic [31:0] mk(input logic [3:0] f,
    input logic [6:0] op, input logic [1:0] m, input logic c,
    input logic [17:0] a);
    return {f, op, m, c, a};
  endfunction : mk
  // clear sticky flags, start, poll done with a bound
  task automatic run(input logic [31:0] ins, input logic [31:0] ctl);
    apb(1'b1, ifd_pkg::OFF_STAT, 32'h3e);
    apb(1'b1, ifd_pkg::OFF_INSTR, ins);
    apb(1'b1, ifd_pkg::OFF_CTRL, ctl | 32'h1);
    for (int i = 0; i < 100; i++)
    begin
      apb(1'b0, ifd_pkg::OFF_STAT, 32'h0);
      if (rd[1] === 1'b1)
        return;
    end
    n_fail++;
    report_and_stop();
  endtask : run
  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdc(ifd_pkg::OFF_STAT, 32'h0);
    apb(1'b0, 8'hfc, 32'h0);
    chk32({31'h0, err}, 32'h1);
    apb(1'b1, ifd_pkg::OFF_EA, 32'h1234);
    rdc(ifd_pkg::OFF_EA, 32'h0);
    mem.word_q[10'h040] = 32'hc1234567;
    run(mk(4'h0, 7'h02, 2'h0, 1'b1, 18'h00100), 32'h0);
    rdc(ifd_pkg::OFF_ACCA, 32'hc1234567);
    rdc(ifd_pkg::OFF_EA, 32'h100);
    rdc(ifd_pkg::OFF_FP, 32'hc1);
    rdc(ifd_pkg::OFF_FPFRAC, 32'h234567);
    rdc(ifd_pkg::OFF_STAT, 32'h202);
    // sum wraps past 18 bits
    apb(1'b1, ifd_pkg::OFF_IDX2, 32'h3fff0);
    run(mk(4'h5, 7'h02, 2'h0, 1'b1, 18'h00020), 32'h0);
    rdc(ifd_pkg::OFF_ACCA, 32'h10);
    lat <= 4'h3;
    apb(1'b1, ifd_pkg::OFF_IDX3, 32'h8);
    mem.word_q[10'h082] = 32'h7;
    run(mk(4'h6, 7'h02, 2'h1, 1'b1, 18'h00200), 32'h0);
    rdc(ifd_pkg::OFF_ACCB, 32'h7);
    rdc(ifd_pkg::OFF_EA, 32'h208);
    apb(1'b1, ifd_pkg::OFF_IDX1, 32'h10);
    mem.word_q[10'h0c0] = mk(4'h8, 7'h0, 2'h0, 1'b0, 18'h00310);
    mem.word_q[10'h0c4] = mk(4'h2, 7'h0, 2'h0, 1'b0, 18'h00400);
    mem.word_q[10'h104] = 32'h5;
    run(mk(4'h8, 7'h02, 2'h0, 1'b1, 18'h00300), 32'h0);
    rdc(ifd_pkg::OFF_EA, 32'h410);
    rdc(ifd_pkg::OFF_ACCA, 32'h5);
    run(mk(4'h9, 7'h02, 2'h0, 1'b1, 18'h00300), 32'h0);
    rdc(ifd_pkg::OFF_ACCA, 32'h410);
    mem.word_q[10'h050] = 32'h0;
    run(mk(4'h0, 7'h02, 2'h0, 1'b0, 18'h00140), 32'h0);
    rdc(ifd_pkg::OFF_STAT, 32'h102);
    run(mk(4'h0, 7'h02, 2'h0, 1'b1, 18'h00140), 32'h0);
    rdc(ifd_pkg::OFF_STAT, 32'h002);
    mem.word_q[10'h140] = 32'h89abcdef;
    mem.word_q[10'h141] = 32'h01234567;
    run(mk(4'h0, 7'h03, 2'h0, 1'b1, 18'h00500), 32'h0);
    rdc(ifd_pkg::OFF_ACCA, 32'h89abcdef);
    rdc(ifd_pkg::OFF_ACCB, 32'h01234567);
    // compares against 5, then logical tests of stored words
    apb(1'b1, ifd_pkg::OFF_ACCA, 32'h5);
    mem.word_q[10'h060] = 32'hffffffff;
    mem.word_q[10'h061] = 32'h0;
    mem.word_q[10'h062] = 32'h0000f0f0;
    for (int i = 0; i < 6; i++)
    begin
      if (i < 3)
        run(mk(4'h1, 7'h02, 2'h0, 1'b1, 18'(3 + 2 * i)), 32'h20);
      else
        run(mk(4'h0, 7'h02, 2'h0, 1'b1, 18'(384 + 4 * (i - 3))), 32'h10);
      apb(1'b0, ifd_pkg::OFF_STAT, 32'h0);
      chk32(rd & 32'h300, {22'h0, cc_exp[i], 8'h00});
    end
    run(mk(4'h1, 7'h06, 2'h2, 1'b0, 18'h00123), 32'h0);
    rdc(ifd_pkg::OFF_IDX2, 32'h123);
    for (int i = 0; i < 3; i++)
    begin
      run(mk(4'h0, mis_op[i], 2'h0, 1'b0, mis_ad[i]), 32'h0);
      chk32(rd & 32'h3e, 32'h12);
    end
    chk32(n_int, 32'h0);
    run(mk(4'h0, 7'h7a, 2'h0, 1'b0, 18'h00100), 32'h0);
    chk32(rd & 32'h3e, 32'h06);
    run(mk(4'h0, 7'h02, 2'h0, 1'b0, 18'h01000), 32'h0);
    chk32(rd & 32'h3e, 32'h0a);
    chk32(n_int, 32'h2);
    apb(1'b1, ifd_pkg::OFF_STDATA, 32'hdeadbeef);
    run(mk(4'h0, 7'h02, 2'h0, 1'b0, 18'h00700), 32'h2);
    chk32(mem.word_q[10'h1c0], 32'hdeadbeef);
    // byte and half loads land in the named lane of a
    apb(1'b1, ifd_pkg::OFF_ACCA, 32'h11223344);
    run(mk(4'h0, 7'h00, 2'h2, 1'b1, 18'h00701), 32'h0);
    rdc(ifd_pkg::OFF_OPHI, 32'h000000ad);
    rdc(ifd_pkg::OFF_ACCA, 32'h1122ad44);
    rdc(ifd_pkg::OFF_STAT, 32'h102);
    run(mk(4'h0, 7'h01, 2'h1, 1'b0, 18'h00702), 32'h0);
    rdc(ifd_pkg::OFF_ACCA, 32'h1122beef);
    // narrow stores merge into the stored word
    run(mk(4'h0, 7'h00, 2'h0, 1'b0, 18'h00700), 32'h2);
    apb(1'b1, ifd_pkg::OFF_STDATA, 32'h12345678);
    run(mk(4'h0, 7'h01, 2'h0, 1'b0, 18'h00702), 32'h2);
    chk32(mem.word_q[10'h1c0], 32'hefad5678);
    // double with zero high word still reads positive
    mem.word_q[10'h142] = 32'h0;
    mem.word_q[10'h143] = 32'h1;
    run(mk(4'h0, 7'h03, 2'h0, 1'b1, 18'h00508), 32'h0);
    chk32(rd, 32'h102);
    rdc(ifd_pkg::OFF_ACCB, 32'h1);
    // second word of a double past the top
    run(mk(4'h0, 7'h03, 2'h0, 1'b0, 18'h00ffc), 32'h0);
    chk32(rd & 32'h3e, 32'h0a);
    chk32(n_int, 32'h3);
    // branches test cc without changing it
    run(mk(4'h1, 7'h0a, 2'h2, 1'b1, 18'h00000), 32'h0);
    chk32(rd & 32'h320, 32'h120);
    run(mk(4'h1, 7'h0a, 2'h3, 1'b1, 18'h00000), 32'h0);
    chk32(rd & 32'h320, 32'h100);
    chk32({31'h0, busy}, 32'h0);
    chk32({31'h0, seen_busy}, 32'h1);
    report_and_stop();
  end
endmodule : test_instruction_field_decode_ea
`default_nettype wire
